// ---- dcs_serial_top.sv ----
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Per channel: registers 1-7 write, 0-2 read
// - Vector register in channel B, readable back
// - Fixed priority: A over B, rx-tx-ext
// - Three-byte receive queue after shift register
// - Error bits queued beside each byte
// - Async 5/6-bit characters right-justified in queue
// - Sync receive starts hunting for sync/flag
// - Monosync: sync register equals second sync
// - Bisync: both sync characters must match
// - After sync, data bypasses sync register
// - SDLC: zero after five ones deleted
// - Sixth one: seventh bit flag or abort
// - SDLC hunts flag from second sync
// - Byte-sync CRC 8-bit delayed; SDLC direct
// - Tx data register and 20-bit shifter
// - Sync fill at start and underrun
// - SDLC flags open and close frame
// - Sync registers: sync chars or address/flag
// - Async tx framed with start/stop bits
// - Sync tx bits feed CRC generator
// - SDLC zero insertion except during flags
// - CTS and carrier detect monitored
// - Reset: marking, outputs high, no interrupts
module dcs_serial_top (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	// Host register port
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Serial lines, index 0 is channel A
	input  wire logic [1:0] i_rxd,
	input  wire logic [1:0] i_rx_clk,
	input  wire logic [1:0] i_tx_clk,
	input  wire logic [1:0] i_cts_n,
	input  wire logic [1:0] i_carrier_detect_n,
	output logic            o_serial_out_a,
	output logic            o_serial_out_b,
	// Modem and interrupt
	output logic      [1:0] o_rts_n,
	output logic      [1:0] o_dtr_n,
	output logic            o_int_n
);
	typedef struct packed {
		logic [7:1][7:0]           wr;
		logic [2:0]                ptr;
		logic [2:0]                rxc_s, txc_s, cts_s, dcd_s;
		logic [1:0]                rxd_s;
		logic                      rx_busy, rx_par, rx_perr, hunt;
		logic [3:0]                rx_cnt;
		logic [7:0]                rx_sh, rx_sync, rx_dly;
		logic [2:0]                rx_ones;
		logic [15:0]               rx_crc;
		logic                      ovr, abort, eof, crc_err;
		logic [7:0]                tx_reg;
		logic                      tx_full, tx_ip, underrun, tx_noz, tx_crc_on;
		logic [19:0]               tx_sh;
		logic [4:0]                tx_left;
		logic [2:0]                tx_ones;
		logic [15:0]               tx_crc;
		dcs_pkg::dcs_tx_phase_type tx_phase;
		logic                      ext_pend, txd, rts_n, dtr_n;
	} dcs_chan_type;

	typedef struct packed {
		dcs_chan_type [1:0] ch;
		logic [7:0]         rdata;
		logic [2:0]         code;
		logic               int_n;
	} dcs_state_type;

	localparam dcs_chan_type CH_RST = '{txd: 1'b1, rts_n: 1'b1, dtr_n: 1'b1, hunt: 1'b1,
		cts_s: 3'h7, dcd_s: 3'h7, tx_phase: dcs_pkg::TX_IDLE, default: '0};

	dcs_state_type q;
	dcs_state_type d;
	logic [1:0]                       push, pop, fclr, rx_go, tx_go;
	logic [1:0][2:0]                  pend;
	logic [1:0][dcs_pkg::FIFO_W-1:0]  pdata;
	logic [1:0][dcs_pkg::FIFO_W-1:0]  head;
	logic [1:0][1:0]                  fcount;

	function automatic logic [3:0] char_bits(input logic [1:0] len);
		case (len)
			2'h0: char_bits = 4'h5;
			2'h1: char_bits = 4'h7;
			2'h2: char_bits = 4'h6;
			default: char_bits = 4'h8;
		endcase
	endfunction : char_bits

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b,
		input logic ccitt);
		logic [15:0] poly;
		poly = ccitt ? dcs_pkg::POLY_CCITT : dcs_pkg::POLY_16;
		crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? poly : 16'h0000);
	endfunction : crc_step

	// --------------------------------
	// Receive queues
	// --------------------------------
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_fifo
			dcs_rx_fifo u_fifo (
				.i_core_clk (i_core_clk),
				.i_rstn     (i_rstn),
				.i_push     (push[g]),
				.i_wdata    (pdata[g]),
				.i_pop      (pop[g]),
				.i_clear    (fclr[g]),
				.o_head     (head[g]),
				.o_count    (fcount[g])
			);
			// Link clock edges, enables
			assign rx_go[g] = q.ch[g].rxc_s[1] & ~q.ch[g].rxc_s[2] & q.ch[g].wr[3][dcs_pkg::RX_EN]
				& (~q.ch[g].wr[3][dcs_pkg::AUTO_EN] | ~q.ch[g].dcd_s[1]);
			assign tx_go[g] = ~q.ch[g].txc_s[1] & q.ch[g].txc_s[2] & q.ch[g].wr[5][dcs_pkg::TX_EN]
				& (~q.ch[g].wr[3][dcs_pkg::AUTO_EN] | ~q.ch[g].cts_s[1]);
		end
	endgenerate

	// --------------------------------
	// Channel logic
	// --------------------------------
	always_comb
	begin
		dcs_chan_type p;
		dcs_chan_type n;
		logic sel, b, sync, sdlc, ccitt, pb, obit;
		logic [3:0] nb;
		logic [1:0] mode;
		logic [4:0] left;
		logic [19:0] sh;
		p = '0;
		n = '0;
		sel = 1'b0;
		b = 1'b0;
		sync = 1'b0;
		sdlc = 1'b0;
		ccitt = 1'b0;
		pb = 1'b0;
		obit = 1'b1;
		nb = 4'h0;
		mode = 2'h0;
		left = 5'h0;
		sh = 20'h0;
		d = q;
		push = 2'h0;
		pop = 2'h0;
		fclr = 2'h0;
		pdata = '0;
		for (int c = 0; c < 2; c++)
		begin
			p = q.ch[c];
			n = p;
			n.rxc_s = {p.rxc_s[1:0], i_rx_clk[c]};
			n.txc_s = {p.txc_s[1:0], i_tx_clk[c]};
			n.cts_s = {p.cts_s[1:0], i_cts_n[c]};
			n.dcd_s = {p.dcd_s[1:0], i_carrier_detect_n[c]};
			n.rxd_s = {p.rxd_s[0], i_rxd[c]};
			mode = p.wr[4][dcs_pkg::MODE_LO+:2];
			sync = p.wr[4][dcs_pkg::STOP_LO+:2] == 2'h0;
			sdlc = sync && mode == dcs_pkg::MODE_SDLC;
			ccitt = sdlc || !p.wr[5][dcs_pkg::CRC16];
			sel = i_addr[dcs_pkg::ADDR_CHB] == c[0];
			if (sel && i_wr && i_addr[dcs_pkg::ADDR_CTRL])
			begin
				if (p.ptr == dcs_pkg::REG_PTR)
				begin
					n.ptr = i_wdata[2:0];
					case (i_wdata[dcs_pkg::CMD_LO+:3])
						dcs_pkg::CMD_EXT_RST: begin n.ext_pend = 1'b0; n.abort = 1'b0; end
						dcs_pkg::CMD_ERR_RST: begin n.ovr = 1'b0; n.eof = 1'b0; n.crc_err = 1'b0; end
						dcs_pkg::CMD_CHAN_RST: begin n = CH_RST; fclr[c] = 1'b1; end
						default: n.ptr = i_wdata[2:0];
					endcase
				end
				else
				begin
					n.wr[p.ptr] = i_wdata;
					n.ptr = dcs_pkg::REG_PTR;
					if (p.ptr == dcs_pkg::REG_RXP && i_wdata[dcs_pkg::HUNT])
						n.hunt = 1'b1;
				end
			end
			if (sel && i_rd && i_addr[dcs_pkg::ADDR_CTRL])
			begin
				n.ptr = dcs_pkg::REG_PTR;
				case (p.ptr)
					dcs_pkg::REG_PTR: d.rdata = {p.abort, p.underrun, ~p.cts_s[1], p.hunt,
						~p.dcd_s[1], ~p.tx_full, ~q.int_n & ~c[0], fcount[c] != 2'h0};
					dcs_pkg::REG_INT: d.rdata = {p.eof, p.crc_err | head[c][10], p.ovr,
						head[c][9], 3'h0, !p.tx_full && p.tx_left == 5'h0};
					dcs_pkg::REG_VECTOR: d.rdata = !c[0] ? 8'h00 : !p.wr[1][dcs_pkg::SAV] ?
						p.wr[2] : {p.wr[2][7:4], q.code, p.wr[2][0]};
					default: d.rdata = 8'h00;
				endcase
			end
			if (sel && i_rd && !i_addr[dcs_pkg::ADDR_CTRL])
			begin
				d.rdata = head[c][7:0];
				pop[c] = 1'b1;
			end
			if (sel && i_wr && !i_addr[dcs_pkg::ADDR_CTRL])
			begin
				n.tx_reg = i_wdata;
				n.tx_full = 1'b1;
				n.tx_ip = 1'b0;
			end
			if (p.cts_s[2] != p.cts_s[1] || p.dcd_s[2] != p.dcd_s[1])
				n.ext_pend = 1'b1;
			if (!p.wr[3][dcs_pkg::RX_EN])
				n.rx_busy = 1'b0;
			// ---- Receive
			b = p.rxd_s[1];
			nb = char_bits(p.wr[3][dcs_pkg::LEN_LO+:2]);
			if (rx_go[c] && !sync)
			begin
				if (!p.rx_busy)
				begin
					n.rx_busy = !b;
					n.rx_cnt = 4'h0;
					n.rx_par = 1'b0;
					n.rx_perr = 1'b0;
				end
				else
				begin
					n.rx_cnt = p.rx_cnt + 4'h1;
					if (p.rx_cnt < nb)
					begin
						n.rx_sh = {b, p.rx_sh[7:1]};
						n.rx_par = p.rx_par ^ b;
					end
					else if (p.wr[4][dcs_pkg::PAR_EN] && p.rx_cnt == nb)
						n.rx_perr = p.rx_par ^ b ^ ~p.wr[4][dcs_pkg::PAR_EVEN];
					else
					begin
						push[c] = 1'b1;
						pdata[c] = {~b, p.rx_perr, 1'b0, p.rx_sh >> (4'h8 - nb)};
						n.rx_busy = 1'b0;
					end
				end
			end
			else if (rx_go[c] && p.hunt)
			begin
				n.rx_sync = {b, p.rx_sync[7:1]};
				n.rx_sh = {p.rx_sync[0], p.rx_sh[7:1]};
				n.rx_cnt = 4'h0;
				n.rx_ones = 3'h0;
				n.rx_crc = dcs_pkg::CRC_PRESET;
				if (mode != dcs_pkg::MODE_BI && n.rx_sync == p.wr[7])
					n.hunt = 1'b0;
				if (mode == dcs_pkg::MODE_BI && n.rx_sync == p.wr[7] && n.rx_sh == p.wr[6])
					n.hunt = 1'b0;
			end
			else if (rx_go[c] && sdlc)
			begin
				if (p.rx_ones == 3'h5 && !b)
					n.rx_ones = 3'h0;
				else if (p.rx_ones == 3'h6)
				begin
					n.rx_ones = 3'h0;
					n.rx_cnt = 4'h0;
					n.abort = n.abort | b;
					n.hunt = b;
					n.eof = n.eof | !b;
					n.crc_err = n.crc_err | (!b && p.rx_crc != dcs_pkg::CRC_PRESET);
					n.rx_crc = dcs_pkg::CRC_PRESET;
				end
				else if (p.rx_ones == 3'h5)
					n.rx_ones = 3'h6;
				else
				begin
					n.rx_ones = b ? p.rx_ones + 3'h1 : 3'h0;
					n.rx_crc = crc_step(p.rx_crc, b, ccitt);
				end
			end
			if (rx_go[c] && sync && !p.hunt && !(sdlc && (p.rx_ones >= 3'h5)))
			begin
				n.rx_sh = {b, p.rx_sh[7:1]};
				n.rx_dly = {b, p.rx_dly[7:1]};
				n.rx_cnt = p.rx_cnt + 4'h1;
				if (!sdlc && p.wr[3][dcs_pkg::RX_CRC_EN])
					n.rx_crc = crc_step(p.rx_crc, p.rx_dly[0], ccitt);
				if (n.rx_cnt == nb)
				begin
					push[c] = 1'b1;
					pdata[c] = {2'h0, n.rx_crc != dcs_pkg::CRC_PRESET, n.rx_sh >> (4'h8 - nb)};
					n.rx_cnt = 4'h0;
				end
			end
			if (push[c] && fcount[c] == 2'h3 && !pop[c])
				n.ovr = 1'b1;
			// ---- Transmit
			nb = char_bits(p.wr[5][dcs_pkg::TX_LEN_LO+:2]);
			sh = p.tx_sh;
			left = p.tx_left;
			obit = p.txd;
			if (tx_go[c] && left == 5'h0)
			begin
				n.tx_noz = 1'b1;
				n.tx_crc_on = 1'b0;
				if (!sync && p.tx_full)
				begin
					sh = 20'hfffff;
					sh[0] = 1'b0;
					pb = ~p.wr[4][dcs_pkg::PAR_EVEN];
					for (int i = 0; i < 8; i++)
						if (i < nb)
						begin
							sh[i+1] = p.tx_reg[i];
							pb = pb ^ p.tx_reg[i];
						end
					if (p.wr[4][dcs_pkg::PAR_EN])
						sh[5'(nb)+5'h1] = ~pb;
					left = 5'(nb) + 5'h2 + {4'h0, p.wr[4][dcs_pkg::PAR_EN]}
						+ {4'h0, p.wr[4][dcs_pkg::STOP_LO+1]};
				end
				else if (sdlc && p.tx_full && p.tx_phase == dcs_pkg::TX_IDLE)
				begin
					sh = {12'h000, p.wr[7]};
					left = 5'h8;
					n.tx_phase = dcs_pkg::TX_DATA;
					n.tx_crc = dcs_pkg::CRC_PRESET;
				end
				else if (sync && p.tx_full)
				begin
					sh = {12'h000, p.tx_reg};
					left = {1'b0, nb};
					n.tx_noz = 1'b0;
					n.tx_crc_on = 1'b1;
				end
				else if (sdlc && p.tx_phase == dcs_pkg::TX_DATA)
				begin
					sh = {4'h0, p.tx_crc};
					left = 5'h10;
					n.tx_noz = 1'b0;
					n.tx_phase = dcs_pkg::TX_CRC;
					n.underrun = 1'b1;
				end
				else if (sdlc)
				begin
					sh = {12'h000, p.wr[7]};
					left = 5'h8;
					n.tx_phase = dcs_pkg::TX_IDLE;
				end
				else if (sync)
				begin
					sh = mode == dcs_pkg::MODE_BI ? {4'h0, p.wr[7], p.wr[6]} : {12'h000, p.wr[7]};
					left = mode == dcs_pkg::MODE_BI ? 5'h10 : 5'h8;
					n.underrun = p.underrun | p.tx_crc_on;
					if (!p.tx_crc_on)
						n.tx_crc = dcs_pkg::CRC_PRESET;
				end
				if (p.tx_full && (!sdlc || p.tx_phase != dcs_pkg::TX_IDLE))
				begin
					n.tx_full = 1'b0;
					n.tx_ip = 1'b1;
				end
			end
			else if (tx_go[c])
			begin
				n.tx_noz = p.tx_noz;
				n.tx_crc_on = p.tx_crc_on;
			end
			if (tx_go[c])
			begin
				if (left == 5'h0)
					obit = 1'b1;
				else if (sdlc && !n.tx_noz && p.tx_ones == 3'h5)
				begin
					obit = 1'b0;
					n.tx_ones = 3'h0;
				end
				else
				begin
					obit = sh[0];
					sh = {1'b0, sh[19:1]};
					left = left - 5'h1;
					n.tx_ones = obit ? p.tx_ones + 3'h1 : 3'h0;
					if (n.tx_crc_on && p.wr[5][dcs_pkg::TX_CRC_EN])
						n.tx_crc = crc_step(n.tx_crc, obit, ccitt);
				end
				n.txd = obit & ~p.wr[5][dcs_pkg::BRK];
			end
			if (!p.wr[5][dcs_pkg::TX_EN])
				n.txd = ~p.wr[5][dcs_pkg::BRK];
			n.tx_sh = sh;
			n.tx_left = left;
			if (p.wr[5][dcs_pkg::RTS] || sync || (!p.tx_full && p.tx_left == 5'h0))
				n.rts_n = ~p.wr[5][dcs_pkg::RTS];
			n.dtr_n = ~p.wr[5][dcs_pkg::DTR];
			d.ch[c] = n;
			pend[c][0] = p.wr[1][dcs_pkg::IE_RX_LO+:2] != 2'h0 && fcount[c] != 2'h0;
			pend[c][1] = p.wr[1][dcs_pkg::IE_TX] && p.tx_ip;
			pend[c][2] = p.wr[1][dcs_pkg::IE_EXT] && p.ext_pend;
		end
		d.code = dcs_pkg::CODE_NONE;
		for (int c = 1; c >= 0; c--)
		begin
			if (pend[c][2])
				d.code = {~c[0], dcs_pkg::SRC_EXT};
			if (pend[c][1])
				d.code = {~c[0], dcs_pkg::SRC_TX};
			if (pend[c][0])
				d.code = {~c[0], dcs_pkg::SRC_RX};
		end
		d.int_n = pend == '0;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			q <= '{ch: '{CH_RST, CH_RST}, int_n: 1'b1, code: dcs_pkg::CODE_NONE, default: '0};
		else
			q <= d;
	end

	assign o_rdata        = q.rdata;
	assign o_serial_out_a = q.ch[0].txd;
	assign o_serial_out_b = q.ch[1].txd;
	assign o_rts_n        = {q.ch[1].rts_n, q.ch[0].rts_n};
	assign o_dtr_n        = {q.ch[1].dtr_n, q.ch[0].dtr_n};
	assign o_int_n        = q.int_n;

	// --------------------------------
	// Checks
	// --------------------------------
	a_reset_marking: assert property (@(posedge i_core_clk)
		!i_rstn |=> o_serial_out_a && o_serial_out_b && o_rts_n == 2'h3 && o_int_n)
		else $error("reset outputs not idle");
	a_ptr_return: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		(i_wr || i_rd) && i_addr[1] && q.ch[i_addr[0]].ptr != 3'h0
		|=> q.ch[$past(i_addr[0])].ptr == 3'h0)
		else $error("pointer did not return to zero");
	a_vector_store: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_wr && i_addr == 2'h3 && q.ch[1].ptr == 3'h2 |=> q.ch[1].wr[2] == $past(i_wdata))
		else $error("vector not stored");
	a_data_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_rd && !i_addr[1] && fcount[i_addr[0]] != 2'h0 |=> o_rdata == $past(head[i_addr[0]][7:0]))
		else $error("read data not oldest byte");
	a_mono_sync: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		rx_go[0] && q.ch[0].hunt && q.ch[0].wr[4][3:2] == 2'h0 && q.ch[0].wr[4][5:4] == 2'h0
		&& {q.ch[0].rxd_s[1], q.ch[0].rx_sync[7:1]} == q.ch[0].wr[7] |=> !q.ch[0].hunt)
		else $error("monosync match missed");
	a_sdlc_zdel: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		rx_go[0] && !q.ch[0].hunt && q.ch[0].wr[4][5:2] == 4'h8 && q.ch[0].rx_ones == 3'h5
		&& !q.ch[0].rxd_s[1] |=> $stable(q.ch[0].rx_cnt) && q.ch[0].rx_ones == 3'h0)
		else $error("stuffed zero kept");
	a_tx_zins: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		tx_go[0] && q.ch[0].wr[4][5:2] == 4'h8 && !q.ch[0].tx_noz && q.ch[0].tx_left != 5'h0
		&& q.ch[0].tx_ones == 3'h5 |=> !o_serial_out_a && $stable(q.ch[0].tx_left))
		else $error("zero not inserted");
	a_prio_chan_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		pend[0][0] |=> q.code == 3'h6 && !o_int_n)
		else $error("channel A receive not first");
	a_prio_rx_tx: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		pend[0] == 3'h0 && pend[1][0] && pend[1][1] |=> q.code == 3'h2)
		else $error("receive not above transmit");
endmodule : dcs_serial_top

// ---- dcs_pkg.sv ----
package dcs_pkg;
	// --------------------------------
	// Host port decode
	// --------------------------------
	localparam int ADDR_CHB  = 0;
	localparam int ADDR_CTRL = 1;
	// --------------------------------
	// Register indices
	// --------------------------------
	localparam logic [2:0] REG_PTR    = 3'h0;
	localparam logic [2:0] REG_INT    = 3'h1;
	localparam logic [2:0] REG_VECTOR = 3'h2;
	localparam logic [2:0] REG_RXP    = 3'h3;
	localparam logic [2:0] REG_MISC   = 3'h4;
	localparam logic [2:0] REG_TXP    = 3'h5;
	localparam logic [7:0] REG_RST    = 8'h00;
	// --------------------------------
	// Field positions
	// --------------------------------
	localparam int CMD_LO    = 3;
	localparam int IE_EXT    = 0;
	localparam int IE_TX     = 1;
	localparam int SAV       = 2;
	localparam int IE_RX_LO  = 3;
	localparam int RX_EN     = 0;
	localparam int RX_CRC_EN = 3;
	localparam int HUNT      = 4;
	localparam int AUTO_EN   = 5;
	localparam int LEN_LO    = 6;
	localparam int PAR_EN    = 0;
	localparam int PAR_EVEN  = 1;
	localparam int STOP_LO   = 2;
	localparam int MODE_LO   = 4;
	localparam int TX_CRC_EN = 0;
	localparam int RTS       = 1;
	localparam int CRC16     = 2;
	localparam int TX_EN     = 3;
	localparam int BRK       = 4;
	localparam int TX_LEN_LO = 5;
	localparam int DTR       = 7;
	// --------------------------------
	// Commands, modes, codes
	// --------------------------------
	localparam logic [2:0] CMD_EXT_RST  = 3'h2;
	localparam logic [2:0] CMD_CHAN_RST = 3'h3;
	localparam logic [2:0] CMD_ERR_RST  = 3'h6;
	localparam logic [1:0] MODE_MONO    = 2'h0;
	localparam logic [1:0] MODE_BI      = 2'h1;
	localparam logic [1:0] MODE_SDLC    = 2'h2;
	localparam logic [1:0] SRC_TX       = 2'h0;
	localparam logic [1:0] SRC_EXT      = 2'h1;
	localparam logic [1:0] SRC_RX       = 2'h2;
	localparam logic [2:0] CODE_NONE    = 3'h3;
	localparam logic [15:0] POLY_16     = 16'h8005;
	localparam logic [15:0] POLY_CCITT  = 16'h1021;
	localparam logic [15:0] CRC_PRESET  = 16'h0000;
	localparam int FIFO_W = 11;
	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_CRC} dcs_tx_phase_type;
endpackage : dcs_pkg

// ---- dcs_rx_fifo.sv ----
`timescale 1ns/10ps
module dcs_rx_fifo (
	// Clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rstn,
	// Fill side
	input  wire logic                        i_push,
	input  wire logic [dcs_pkg::FIFO_W-1:0]  i_wdata,
	// Drain side
	input  wire logic                        i_pop,
	input  wire logic                        i_clear,
	output logic      [dcs_pkg::FIFO_W-1:0]  o_head,
	output logic      [1:0]                  o_count
);
	typedef struct packed {
		logic [2:0][dcs_pkg::FIFO_W-1:0] slot;
		logic [1:0]                      count;
	} dcs_fifo_type;

	dcs_fifo_type q;
	dcs_fifo_type d;

	always_comb
	begin
		logic [1:0] cnt;
		cnt = q.count;
		d = q;
		if (i_clear)
		begin
			d = '0;
		end
		else
		begin
			if (i_pop && cnt != 2'h0)
			begin
				d.slot = {{dcs_pkg::FIFO_W{1'b0}}, q.slot[2:1]};
				cnt = cnt - 2'h1;
			end
			if (i_push && cnt != 2'h3)
			begin
				d.slot[cnt] = i_wdata;
				cnt = cnt + 2'h1;
			end
			d.count = cnt;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rstn)
			q <= '0;
		else
			q <= d;
	end

	assign o_head  = q.slot[0];
	assign o_count = q.count;

	a_fifo_full_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		q.count == 2'h3 && i_push && !i_pop && !i_clear |=> q.count == 2'h3 && $stable(q.slot))
		else $error("full queue changed on push");
	a_fifo_err_pair: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		q.count == 2'h0 && i_push && !i_clear |=> o_head == $past(i_wdata))
		else $error("status bits not kept with byte");
endmodule : dcs_rx_fifo

// ---- dcs_line_model.sv ----
`timescale 1ns/10ps
module dcs_line_model (
	// Link clocks and receive data
	output logic      o_rx_clk,
	output logic      o_tx_clk,
	output logic      o_rxd,
	// Transmit data from the block
	input  wire logic i_txd
);
	// --------------------------------
	// Idle line
	// --------------------------------
	initial
	begin
		o_rx_clk = 1'b0;
		o_tx_clk = 1'b1;
		o_rxd    = 1'b1;
	end
	// --------------------------------
	// Bit shifting, clocks only in frames
	// --------------------------------
	task send(input logic [19:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			o_rxd = b[i];
			#80 o_rx_clk = 1'b1;
			#80 o_rx_clk = 1'b0;
		end
		o_rxd = 1'b1;
	endtask : send
	task get(input int n, output logic [31:0] v);
		v = 32'h0;
		for (int i = 0; i < n; i++)
		begin
			#80 o_tx_clk = 1'b0;
			#80 o_tx_clk = 1'b1;
			v[i] = i_txd;
		end
	endtask : get
endmodule : dcs_line_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic        i_core_clk  = 1'b0;
	logic        i_rstn      = 1'b1;
	logic [1:0]  i_addr      = 2'h0;
	logic [7:0]  i_wdata     = 8'h00;
	logic        i_wr        = 1'b0;
	logic        i_rd        = 1'b0;
	logic [1:0]  i_cts_n     = 2'h3;
	logic [1:0]  i_cd_n      = 2'h3;
	logic [7:0]  o_rdata;
	logic        out_a;
	logic        out_b;
	logic        rxc;
	logic        txc;
	logic        rxd;
	logic [1:0]  rts_n;
	logic [1:0]  dtr_n;
	logic        int_n;
	logic [7:0]  v;
	logic [31:0] w;
	logic        hit;
	int          mismatches  = 0;
	int          comparisons = 0;
	logic [7:0]  dat [3]     = '{8'h3c, 8'h5a, 8'h81};
	logic [7:0]  pat [2]     = '{8'h16, 8'h7e};
	logic [7:0]  md [2]      = '{8'h00, 8'h20};

	always #5 i_core_clk = ~i_core_clk;

	dcs_serial_top DUT (
		.i_core_clk         (i_core_clk),
		.i_rstn             (i_rstn),
		.i_addr             (i_addr),
		.i_wdata            (i_wdata),
		.i_wr               (i_wr),
		.i_rd               (i_rd),
		.o_rdata            (o_rdata),
		.i_rxd              ({rxd, rxd}),
		.i_rx_clk           ({rxc, rxc}),
		.i_tx_clk           ({txc, txc}),
		.i_cts_n            (i_cts_n),
		.i_carrier_detect_n (i_cd_n),
		.o_serial_out_a     (out_a),
		.o_serial_out_b     (out_b),
		.o_rts_n            (rts_n),
		.o_dtr_n            (dtr_n),
		.o_int_n            (int_n)
	);
	dcs_line_model line (
		.o_rx_clk (rxc),
		.o_tx_clk (txc),
		.o_rxd    (rxd),
		.i_txd    (out_a)
	);
	// --------------------------------
	// Access tasks
	// --------------------------------
	task check(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task final_report;
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task rst;
		@(posedge i_core_clk);
		i_rstn <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		i_rstn <= 1'b1;
	endtask : rst
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [1:0] a);
		@(posedge i_core_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	task creg(input logic ch, input logic [2:0] r, input logic [7:0] d);
		wr({1'b1, ch}, {5'h00, r});
		wr({1'b1, ch}, d);
	endtask : creg
	task crd(input logic ch, input logic [2:0] r);
		if (r != 3'h0)
			wr({1'b1, ch}, {5'h00, r});
		rd({1'b1, ch});
	endtask : crd
	task cfg(input logic [7:0] m, input logic [7:0] s6, input logic [7:0] s7,
		input logic [7:0] r3);
		rst();
		creg(1'b0, 3'h4, m);
		creg(1'b0, 3'h6, s6);
		creg(1'b0, 3'h7, s7);
		creg(1'b0, 3'h3, r3);
	endtask : cfg
	// --------------------------------
	// Tests
	// --------------------------------
	initial
	begin
		rst();
		#1 check({1'b0, out_a, out_b, int_n, rts_n, dtr_n}, 8'h7f);
		crd(1'b0, 3'h0);
		check(v & 8'h10, 8'h10);
		creg(1'b1, 3'h2, 8'ha5);
		crd(1'b1, 3'h2);
		check(v, 8'ha5);
		crd(1'b1, 3'h0);
		check(v & 8'h10, 8'h10);
		crd(1'b0, 3'h2);
		check(v, 8'h00);
		@(posedge i_core_clk);
		i_cts_n <= 2'h0;
		i_cd_n  <= 2'h0;
		repeat (4) @(posedge i_core_clk);
		crd(1'b0, 3'h0);
		check(v & 8'h28, 8'h28);
		i_cts_n <= 2'h3;
		i_cd_n  <= 2'h3;
		creg(1'b0, 3'h5, 8'h82);
		repeat (2) @(posedge i_core_clk);
		#1 check({4'h0, rts_n, dtr_n}, 8'h0a);
		rst();
		#1 check({4'h0, rts_n, dtr_n}, 8'h0f);
		cfg(8'h00, 8'h00, 8'h16, 8'hd1);
		line.send(8'h16, 8);
		crd(1'b0, 3'h0);
		check(v & 8'h10, 8'h00);
		for (int i = 0; i < 3; i++)
			line.send(dat[i], 8);
		line.send(8'hff, 8);
		for (int i = 0; i < 3; i++)
		begin
			rd(2'h0);
			check(v, dat[i]);
		end
		crd(1'b0, 3'h1);
		check(v, 8'h21);
		cfg(8'h10, 8'h32, 8'h16, 8'hd1);
		line.send(8'h32, 8);
		crd(1'b0, 3'h0);
		check(v & 8'h10, 8'h10);
		line.send(8'h16, 8);
		crd(1'b0, 3'h0);
		check(v & 8'h10, 8'h00);
		cfg(8'h20, 8'h00, 8'h7e, 8'hd1);
		line.send(8'h7e, 8);
		crd(1'b0, 3'h0);
		check(v & 8'h10, 8'h00);
		line.send(9'h1df, 9);
		line.send(8'h3c, 8);
		line.send(8'h7e, 8);
		rd(2'h0);
		check(v, 8'hff);
		rd(2'h0);
		check(v, 8'h3c);
		line.send(8'hff, 8);
		crd(1'b0, 3'h0);
		check(v & 8'h80, 8'h80);
		cfg(8'h04, 8'h00, 8'h00, 8'hc1);
		line.send(10'h2b4, 10);
		i_cts_n <= 2'h0;
		creg(1'b1, 3'h1, 8'h05);
		creg(1'b0, 3'h1, 8'h19);
		crd(1'b1, 3'h2);
		check(v, 8'h0c);
		check({7'h00, int_n}, 8'h00);
		rd(2'h0);
		check(v, 8'h5a);
		crd(1'b1, 3'h2);
		check(v, 8'h0a);
		wr(2'h2, 8'h10);
		crd(1'b1, 3'h2);
		check(v, 8'h02);
		creg(1'b0, 3'h3, 8'h01);
		line.send(7'h6a, 7);
		rd(2'h0);
		check(v & 8'h1f, 8'h15);
		line.send(7'h2a, 7);
		crd(1'b0, 3'h1);
		check(v, 8'h41);
		cfg(8'h04, 8'h00, 8'h00, 8'h00);
		creg(1'b0, 3'h5, 8'h68);
		creg(1'b1, 3'h4, 8'h04);
		creg(1'b1, 3'h3, 8'hc1);
		creg(1'b1, 3'h5, 8'h68);
		creg(1'b1, 3'h1, 8'h1e);
		wr(2'h1, 8'h3c);
		wr(2'h0, 8'ha5);
		line.get(10, w);
		check(w[8:1], 8'ha5);
		check({6'h00, w[9], w[0]}, 8'h02);
		check({7'h00, out_b}, 8'h01);
		line.send(10'h2b4, 10);
		crd(1'b1, 3'h2);
		check(v, 8'h04);
		rd(2'h1);
		check(v, 8'h5a);
		crd(1'b1, 3'h2);
		check(v, 8'h00);
		for (int m = 0; m < 2; m++)
		begin
			cfg(md[m], 8'h00, pat[m], 8'h00);
			creg(1'b0, 3'h5, 8'h68);
			line.get(32, w);
			hit = 1'b0;
			for (int k = 0; k < 17; k++)
				if (w[k +: 16] === {pat[m], pat[m]})
					hit = 1'b1;
			check({7'h00, hit}, 8'h01);
		end
		cfg(8'h20, 8'h00, 8'h7e, 8'h00);
		creg(1'b0, 3'h5, 8'h68);
		wr(2'h0, 8'hff);
		line.get(17, w);
		check(w[7:0], 8'h7e);
		check(w[15:8], 8'hdf);
		check({7'h00, w[16]}, 8'h01);
		final_report();
	end
	initial
	begin
		#600000;
		mismatches++;
		final_report();
	end
endmodule : tb_top
